// [sxt_pkg.sv]
package sxt_pkg;

	// ********************************
	// Opcode fields
	// ********************************
	localparam logic [5:0] OP_NIBBLE_SWAP = 6'h0e;
	localparam logic [5:0] OP_XOR_FILE    = 6'h06;
	localparam logic [5:0] OP_XOR_LIT     = 6'h3a;
	localparam logic [10:0] OP_DIR_LOAD   = 11'h00c;
	localparam int DEST_BIT   = 7;
	localparam logic [2:0] DIR_FIRST = 3'h5;
	localparam logic [2:0] DIR_LAST  = 3'h7;
	localparam logic [6:0] DIR_FILE_BASE = 7'h05;

	// ********************************
	// Reset values
	// ********************************
	localparam logic [7:0] W_RESET   = 8'h00;
	localparam logic [7:0] DIR_RESET = 8'hff;

	typedef struct packed {
		logic       wrEn;
		logic [6:0] addr;
		logic [7:0] data;
	} sxt_fwr_t;

	typedef struct packed {
		logic [7:0]      w;
		logic            zeroSet;
		logic            zeroVal;
		sxt_fwr_t        fileWr;
		logic [2:0][7:0] dir;
		logic [7:0]      rdData;
		logic            illegal;
	} sxt_state_t;

endpackage

// [sxt_exec.sv]
`timescale 1ns/10ps
module sxt_exec (
	input  wire logic                   clk,
	input  wire logic                   resetn,
	input  wire logic                   instrValid,
	input  wire logic [13:0]            instr,
	input  wire logic [7:0]             fileRdData,
	input  wire logic                   extWrEn,
	input  wire logic [6:0]             extAddr,
	input  wire logic [7:0]             extWrData,
	output logic [7:0]                  wReg,
	output logic                        zeroSet,
	output logic                        zeroVal,
	output sxt_pkg::sxt_fwr_t           fileWr,
	output logic [2:0][7:0]             dirRegs,
	output logic [7:0]                  dirRdData,
	output logic                        illegalOp
);

	// ********************************
	// State
	// ********************************
	sxt_pkg::sxt_state_t state_q;
	sxt_pkg::sxt_state_t state_d;

	// ********************************
	// Instruction fields and external direction offset
	// ********************************
	logic [6:0]  fAddr;
	logic        dest;
	logic [7:0]  litVal;
	logic [5:0]  majorOp;
	logic [10:0] dirOpField;
	logic [2:0]  dirSel;
	logic [6:0]  dirOff;

	assign fAddr      = instr[6:0];
	assign dest       = instr[sxt_pkg::DEST_BIT];
	assign litVal     = instr[7:0];
	assign majorOp    = instr[13:8];
	assign dirOpField = instr[13:3];
	assign dirSel     = instr[2:0];
	assign dirOff     = extAddr - sxt_pkg::DIR_FILE_BASE;

	// ********************************
	// Opcode decode
	// ********************************
	logic       isSwap;
	logic       isXorFile;
	logic       isXorLit;
	logic       isDirLoad;
	logic       dirSelOk;
	logic       dirLoadOk;
	logic       dirLoadBad;
	logic [1:0] dirLoadIdx;

	assign isSwap     = instrValid && (majorOp == sxt_pkg::OP_NIBBLE_SWAP);
	assign isXorFile  = instrValid && (majorOp == sxt_pkg::OP_XOR_FILE);
	assign isXorLit   = instrValid && (majorOp == sxt_pkg::OP_XOR_LIT);
	assign isDirLoad  = instrValid && (dirOpField == sxt_pkg::OP_DIR_LOAD);
	assign dirSelOk   = (dirSel >= sxt_pkg::DIR_FIRST) && (dirSel <= sxt_pkg::DIR_LAST);
	assign dirLoadOk  = isDirLoad && dirSelOk;
	assign dirLoadBad = isDirLoad && !dirSelOk;
	assign dirLoadIdx = 2'(dirSel - sxt_pkg::DIR_FIRST);

	// ********************************
	// Direction register access
	// ********************************
	localparam int DIR_COUNT = int'(sxt_pkg::DIR_LAST) - int'(sxt_pkg::DIR_FIRST) + 1;

	logic [DIR_COUNT-1:0]    dirHit;
	logic [DIR_COUNT-1:0]    dirWrHit;
	logic [DIR_COUNT-1:0]    dirLoadHit;
	logic [DIR_COUNT:0][7:0] dirRdChain;
	logic [7:0]              dirRdSel;

	assign dirRdChain[0] = 8'h00;

	for (genvar i = 0; i < DIR_COUNT; i++) begin : gDirSlot
		assign dirHit[i]       = (dirOff == 7'(i));
		assign dirWrHit[i]     = extWrEn && dirHit[i];
		assign dirLoadHit[i]   = dirLoadOk && (dirLoadIdx == 2'(i));
		assign dirRdChain[i+1] = dirRdChain[i] | (dirHit[i] ? state_q.dir[i] : 8'h00);
	end

	assign dirRdSel = dirRdChain[DIR_COUNT];

	// ********************************
	// Result datapath
	// ********************************
	logic [7:0]        swapRes;
	logic [7:0]        xorFileRes;
	logic [7:0]        xorLitRes;
	logic              xorFileZero;
	logic              xorLitZero;
	sxt_pkg::sxt_fwr_t swapWr;
	sxt_pkg::sxt_fwr_t xorWr;

	assign swapRes     = {fileRdData[3:0], fileRdData[7:4]};
	assign xorFileRes  = state_q.w ^ fileRdData;
	assign xorLitRes   = state_q.w ^ litVal;
	assign xorFileZero = (xorFileRes == 8'h00);
	assign xorLitZero  = (xorLitRes == 8'h00);
	assign swapWr      = '{wrEn: 1'b1, addr: fAddr, data: swapRes};
	assign xorWr       = '{wrEn: 1'b1, addr: fAddr, data: xorFileRes};

	// ********************************
	// Destination select
	// ********************************
	logic swapToFile;
	logic swapToW;
	logic xorToFile;
	logic xorToW;

	assign swapToFile = isSwap && dest;
	assign swapToW    = isSwap && !dest;
	assign xorToFile  = isXorFile && dest;
	assign xorToW     = isXorFile && !dest;

	// ********************************
	// Next state
	// ********************************
	always_comb begin
		state_d             = state_q;
		state_d.zeroSet     = 1'b0;
		state_d.fileWr.wrEn = 1'b0;
		state_d.illegal     = 1'b0;
		state_d.rdData      = dirRdSel;

		for (int k = 0; k < DIR_COUNT; k++) begin
			if (dirWrHit[k]) begin
				state_d.dir[k] = extWrData;
			end
		end

		for (int k = 0; k < DIR_COUNT; k++) begin
			if (dirLoadHit[k]) begin
				state_d.dir[k] = state_q.w;
			end
		end

		if (dirLoadBad) begin
			state_d.illegal = 1'b1;
		end

		if (swapToFile) begin
			state_d.fileWr = swapWr;
		end
		if (swapToW) begin
			state_d.w = swapRes;
		end

		if (isXorFile) begin
			state_d.zeroSet = 1'b1;
			state_d.zeroVal = xorFileZero;
		end
		if (xorToFile) begin
			state_d.fileWr = xorWr;
		end
		if (xorToW) begin
			state_d.w = xorFileRes;
		end

		if (isXorLit) begin
			state_d.zeroSet = 1'b1;
			state_d.zeroVal = xorLitZero;
			state_d.w       = xorLitRes;
		end
	end

	// ********************************
	// Registers
	// ********************************
	always_ff @(posedge clk) begin
		if (!resetn) begin
			state_q.w       <= sxt_pkg::W_RESET;
			state_q.zeroSet <= 1'b0;
			state_q.zeroVal <= 1'b0;
			state_q.fileWr  <= '0;
			state_q.dir     <= {3{sxt_pkg::DIR_RESET}};
			state_q.rdData  <= 8'h00;
			state_q.illegal <= 1'b0;
		end else begin
			state_q <= state_d;
		end
	end

	// ********************************
	// Outputs
	// ********************************
	assign wReg      = state_q.w;
	assign zeroSet   = state_q.zeroSet;
	assign zeroVal   = state_q.zeroVal;
	assign fileWr    = state_q.fileWr;
	assign dirRegs   = state_q.dir;
	assign dirRdData = state_q.rdData;
	assign illegalOp = state_q.illegal;

endmodule // sxt_exec

// [sxt_exec_assertions.sv]
`timescale 1ns/10ps
module sxt_exec_chk (
	input wire logic              clk,
	input wire logic              resetn,
	input wire logic              instrValid,
	input wire logic [13:0]       instr,
	input wire logic [7:0]        fileRdData,
	input wire logic [7:0]        wReg,
	input wire logic              zeroSet,
	input wire logic              zeroVal,
	input wire sxt_pkg::sxt_fwr_t fileWr,
	input wire logic [2:0][7:0]   dirRegs,
	input wire logic              illegalOp
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	chk_swap_file: assert property (instrValid && instr[13:7] == 7'h1d |=> fileWr.wrEn &&
		fileWr.data == {$past(fileRdData[3:0]), $past(fileRdData[7:4])}) else $error("swap f");
	chk_swap_w: assert property (instrValid && instr[13:7] == 7'h1c |=> !zeroSet &&
		wReg == {$past(fileRdData[3:0]), $past(fileRdData[7:4])}) else $error("swap w");
	chk_dir_load: assert property (instrValid && instr == 14'h0067 |=>
		dirRegs[2] == $past(wReg) && !zeroSet) else $error("dir load");
	chk_dir_refuse: assert property (instrValid && instr[13:3] == 11'h00c &&
		instr[2:0] < 3'h5 |=> illegalOp) else $error("dir refuse");
	chk_xor_lit: assert property (instrValid && instr[13:8] == 6'h3a |=> zeroSet &&
		zeroVal == (wReg == 8'h00) && wReg == ($past(wReg) ^ $past(instr[7:0]))) else $error("xor");
	chk_xor_file: assert property (instrValid && instr[13:8] == 6'h06 |=> zeroSet &&
		zeroVal == (($past(wReg) ^ $past(fileRdData)) == 8'h00)) else $error("xor file");
	chk_illegal_quiet: assert property (!(instrValid && instr[13:3] == 11'h00c &&
		instr[2:0] < 3'h5) |=> !illegalOp) else $error("spurious illegal");
endmodule // sxt_exec_chk
bind sxt_exec sxt_exec_chk sxt_exec_chk_inst (.*);

// [swap_xor_direction_load_op_exec_test.sv]
`timescale 1ns/10ps
module swap_xor_direction_load_op_exec_test;
	logic clk = 0, resetn = 0, instrValid = 0, extWrEn = 0, zeroSet, zeroVal, illegalOp;
	logic [13:0] instr = 0;
	logic [7:0] fileRdData = 0, extWrData = 0, wReg, dirRdData;
	logic [6:0] extAddr = 0;
	sxt_pkg::sxt_fwr_t fileWr;
	logic [2:0][7:0] dirRegs;
	int fails = 0, n_checks = 0, cyc = 0;
	always #2 clk = ~clk;
	sxt_exec sxt_exec_inst (
		.clk        (clk),
		.resetn     (resetn),
		.instrValid (instrValid),
		.instr      (instr),
		.fileRdData (fileRdData),
		.extWrEn    (extWrEn),
		.extAddr    (extAddr),
		.extWrData  (extWrData),
		.wReg       (wReg),
		.zeroSet    (zeroSet),
		.zeroVal    (zeroVal),
		.fileWr     (fileWr),
		.dirRegs    (dirRegs),
		.dirRdData  (dirRdData),
		.illegalOp  (illegalOp)
	);
	task automatic chk(logic [31:0] s, logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			fails++;
			$display("[ERR] %0t got %h want %h", $time, s, e);
		end
	endtask
	task automatic run(logic [13:0] i, logic [7:0] f);
		@(posedge clk);
		instrValid <= 1;
		instr <= i;
		fileRdData <= f;
		@(posedge clk);
		instrValid <= 0;
		#1;
	endtask
	task automatic conclude;
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic t_swap;
		run(14'h0e85, 8'ha5);
		chk(fileWr, 16'h855a);
		run(14'h0e05, 8'hc3);
		chk({fileWr.wrEn, zeroSet, wReg}, 16'h003c);
		$display("t_swap end");
	endtask
	task automatic t_xor;
		run(14'h3aaf, 8'h00);
		chk({zeroSet, zeroVal, wReg}, 16'h0293);
		run(14'h0685, 8'h93);
		chk({zeroVal, fileWr}, 17'h18500);
		$display("t_xor end");
	endtask
	task automatic t_dir;
		run(14'h0067, 8'h00);
		chk(dirRegs[2], 8'h93);
		run(14'h0064, 8'h00);
		chk({illegalOp, dirRegs[0]}, 16'h01ff);
		@(posedge clk);
		extWrEn <= 1;
		extAddr <= 7'h06;
		extWrData <= 8'h42;
		@(posedge clk);
		extWrEn <= 0;
		@(posedge clk);
		#1;
		chk({dirRegs[1], dirRdData}, 16'h4242);
		$display("t_dir end");
	endtask
	task automatic t_xor_dest;
		run(14'h0605, 8'h0f);
		chk({fileWr.wrEn, zeroSet, zeroVal, wReg}, 32'h29c);
		run(14'h3a9c, 8'h00);
		chk({zeroSet, zeroVal, wReg}, 32'h300);
		run(14'h3ab5, 8'h00);
		run(14'h3aaf, 8'h00);
		chk({zeroSet, zeroVal, wReg}, 32'h21a);
		@(posedge clk);
		#1;
		chk({zeroSet, fileWr.wrEn}, 32'h0);
		$display("t_xor_dest end");
	endtask
	task automatic t_dir_more;
		run(14'h0065, 8'h00);
		chk(dirRegs[0], 32'h1a);
		run(14'h0066, 8'h00);
		chk(dirRegs, 32'h931a1a);
		run(14'h0060, 8'h00);
		chk({illegalOp, dirRegs}, 32'h1931a1a);
		@(posedge clk);
		#1;
		chk(illegalOp, 32'h0);
		@(posedge clk);
		instrValid <= 1;
		instr <= 14'h0067;
		extWrEn <= 1;
		extAddr <= 7'h07;
		extWrData <= 8'h77;
		@(posedge clk);
		instrValid <= 0;
		extWrEn <= 0;
		#1;
		chk(dirRegs[2], 32'h1a);
		@(posedge clk);
		extWrEn <= 1;
		extAddr <= 7'h05;
		extWrData <= 8'h3c;
		@(posedge clk);
		extWrEn <= 0;
		@(posedge clk);
		#1;
		chk({dirRegs[0], dirRdData}, 32'h3c3c);
		@(posedge clk);
		extWrEn <= 1;
		extAddr <= 7'h04;
		extWrData <= 8'h00;
		@(posedge clk);
		extWrEn <= 0;
		@(posedge clk);
		#1;
		chk({dirRegs, dirRdData}, 32'h1a1a3c00);
		$display("t_dir_more end");
	endtask
	task automatic t_reset;
		@(posedge clk);
		resetn <= 0;
		extAddr <= 7'h06;
		repeat (2) @(posedge clk);
		resetn <= 1;
		#1;
		chk({wReg, dirRegs}, 32'h00ffffff);
		chk({zeroSet, fileWr.wrEn, illegalOp, dirRdData}, 32'h0);
		run(14'h3a5a, 8'h00);
		chk({dirRdData, zeroSet, zeroVal, wReg}, 32'h3fe5a);
		$display("t_reset end");
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 500) begin
			fails++;
			conclude();
		end
	end
	initial begin
		repeat (8) @(posedge clk);
		resetn <= 1;
		#1;
		chk({wReg, dirRegs[0]}, 16'h00ff);
		t_swap();
		t_xor();
		t_dir();
		t_xor_dest();
		t_dir_more();
		t_reset();
		conclude();
	end
endmodule // swap_xor_direction_load_op_exec_test
